//--- hdl/ssi_chan_pkg.sv
/*
 * package for the synchronous serial channel: register map, field
 * positions, reset values, timing counts and status layout.
 * assumes a 250 MHz core clock and an APB slave with 32-bit data.
 */
package ssi_chan_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CtrlOfs      = 8'h00;
    localparam logic [7:0] BaudDivOfs   = 8'h04;
    localparam logic [7:0] MDelayOfs    = 8'h08;
    localparam logic [7:0] MPauseOfs    = 8'h0c;
    localparam logic [7:0] MTimeoutOfs  = 8'h10;
    localparam logic [7:0] SDelayOfs    = 8'h14;
    localparam logic [7:0] SPauseOfs    = 8'h18;
    localparam logic [7:0] STimeoutOfs  = 8'h1c;
    localparam logic [7:0] StatusOfs    = 8'h20;
    localparam logic [7:0] RxDataOfs    = 8'h24;
    localparam logic [7:0] TxDataOfs    = 8'h28;
    localparam logic [7:0] DebounceOfs  = 8'h2c;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CtrlMasterEnBit = 0;
    localparam int CtrlSlaveEnBit  = 1;
    localparam int CtrlMTrigBit    = 2;
    localparam int CtrlSTrigBit    = 3;
    localparam int CtrlStampBit    = 4;
    localparam int CtrlMDebBit     = 5;
    localparam int CtrlSDebBit     = 6;
    localparam int CtrlPllBit      = 7;
    localparam int CtrlLenLsb      = 8;
    localparam int CtrlLenMsb      = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CtrlReset     = 32'h0000_1f00;
    localparam logic [31:0] BaudDivReset  = 32'h0000_0021;
    localparam logic [31:0] DelayReset    = 32'h0000_0000;
    localparam logic [31:0] PauseReset    = 32'h0000_0100;
    localparam logic [31:0] TimeoutReset  = 32'h0000_0100;
    localparam logic [31:0] DebounceReset = 32'h0000_0004;

    // ------------------------------------------------------------
    // sizes and limits
    // ------------------------------------------------------------
    localparam int RxDepth     = 2048;
    localparam int TxDepth     = 1024;
    localparam int RxAw        = 11;
    localparam int TxAw        = 10;
    localparam logic [4:0] MinLenM1 = 5'h02;
    localparam logic [7:0] TwoDelayShift = 8'h01;

    // status bit positions
    localparam int StMErr   = 0;
    localparam int StSErr   = 1;
    localparam int StTxE    = 2;
    localparam int StRxE    = 3;
    localparam int StSBusy  = 4;
    localparam int StMBusy  = 5;
    localparam int StTxHalf = 6;
    localparam int StRxHalf = 7;
    localparam int StTxFull = 8;
    localparam int StRxFull = 9;

    typedef struct packed {
        logic clk;
        logic dat;
    } line_s;

endpackage

//--- hdl/ssi_chan.sv
/*
 * one synchronous serial channel: clock-driving receiver port with a
 * receive fifo and optional stamps, clock-following sender port with a
 * transmit fifo, timing checks, status and an APB register file.
 * assumes pins arrive asynchronous to clk; all delays count core cycles.
 */
// The placing of the registers and register access over APB were left to the implementer.
module ssi_chan
    import ssi_chan_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        globalTrigger,
    input  wire logic        pllTick,
    input  wire logic        masterSerialIn,
    output logic             masterClockOut,
    input  wire logic        slaveClockIn,
    output logic             slaveSerialOut,
    output logic             fifoFullEvent
);


    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d, baud_q, baud_d, mDel_q, mDel_d, mPause_q, mPause_d;
    logic [31:0] mTo_q, mTo_d, sDel_q, sDel_d, sPause_q, sPause_d, sTo_q, sTo_d;
    logic [31:0] deb_q, deb_d;
    logic        mErr_q, mErr_d, sErr_q, sErr_d;
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic        acc, wr, rd;
    logic [4:0]  lenM1;
    logic        setMErr, setSErr;
    logic        rxPop, txPush;

    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;
    assign rd  = acc && !pwrite;
    assign lenM1 = (ctrl_q[CtrlLenMsb:CtrlLenLsb] < MinLenM1) ? MinLenM1
                 : ctrl_q[CtrlLenMsb:CtrlLenLsb];

    // ------------------------------------------------------------
    // pin synchronisers and debounce
    // ------------------------------------------------------------
    line_s mSy1_q, mSy2_q, sSy1_q, sSy2_q;
    line_s mFlt_q, mFlt_d, sFlt_q, sFlt_d;
    logic [7:0] mCnt_q, mCnt_d, sCnt_q, sCnt_d;

    // two flops; only the second is read by anything
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mSy1_q <= '1; mSy2_q <= '1; sSy1_q <= '1; sSy2_q <= '1;
        end
        else
        begin
            mSy1_q <= '{clk: 1'b1, dat: masterSerialIn};
            mSy2_q <= mSy1_q;
            sSy1_q <= '{clk: slaveClockIn, dat: 1'b1};
            sSy2_q <= sSy1_q;
        end
    end

    // filter accepts a change only once it held for the set count
    always_comb
    begin
        mFlt_d = mFlt_q;
        sFlt_d = sFlt_q;
        mCnt_d = 8'h00;
        sCnt_d = 8'h00;
        if (!ctrl_q[CtrlMDebBit] || mSy2_q == mFlt_q) mFlt_d = mSy2_q;
        else if (mCnt_q >= deb_q[7:0]) mFlt_d = mSy2_q;
        else mCnt_d = mCnt_q + 8'h01;
        if (!ctrl_q[CtrlSDebBit] || sSy2_q == sFlt_q) sFlt_d = sSy2_q;
        else if (sCnt_q >= deb_q[15:8]) sFlt_d = sSy2_q;
        else sCnt_d = sCnt_q + 8'h01;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mFlt_q <= '1; sFlt_q <= '1; mCnt_q <= 8'h00; sCnt_q <= 8'h00;
        end
        else
        begin
            mFlt_q <= mFlt_d; sFlt_q <= sFlt_d; mCnt_q <= mCnt_d; sCnt_q <= sCnt_d;
        end
    end

    // ------------------------------------------------------------
    // baud divider: half-bit ticks for the master clock generator
    // ------------------------------------------------------------
    logic [31:0] div_q, div_d;
    logic        half;
    // pll source advances only on its synchronised ticks
    logic pll1_q, pll2_q, pll3_q, src;
    assign src  = ctrl_q[CtrlPllBit] ? (pll2_q && !pll3_q) : 1'b1;
    assign half = src && (div_q >= baud_q);
    always_comb
    begin
        div_d = div_q;
        if (src) div_d = half ? 32'h0 : div_q + 32'h1;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= 32'h0; pll1_q <= 1'b0; pll2_q <= 1'b0; pll3_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d; pll1_q <= pllTick; pll2_q <= pll1_q; pll3_q <= pll2_q;
        end
    end

    // ------------------------------------------------------------
    // fifos (rx holds words, and stamps when enabled)
    // ------------------------------------------------------------
    logic [31:0] rxMem [RxDepth];
    logic [31:0] txMem [TxDepth];
    logic [RxAw:0] rxWp_q, rxWp_d, rxRp_q, rxRp_d;
    logic [TxAw:0] txWp_q, txWp_d, txRp_q, txRp_d;
    logic [RxAw:0] rxCnt;
    logic [TxAw:0] txCnt;
    logic rxFull, txFull, txEmpty, rxEmpty;
    assign rxCnt  = rxWp_q - rxRp_q;
    assign txCnt  = txWp_q - txRp_q;
    assign rxFull = rxCnt[RxAw];
    assign txFull = txCnt[TxAw];
    assign rxEmpty = (rxCnt == '0);
    assign txEmpty = (txCnt == '0);

    // ------------------------------------------------------------
    // master port: clock generator and receiver
    // ------------------------------------------------------------
    typedef enum {MIdle, MLow, MHigh, MPause} mst_e;
    mst_e mSt_q, mSt_d;
    logic [5:0]  mBit_q, mBit_d;
    logic [31:0] mSh_q, mSh_d, mTmr_q, mTmr_d, stamp_q;
    logic [7:0]  mSmp_q, mSmp_d;
    logic        mSmpGo_q, mSmpGo_d, mClk_d, mBad_q, mBad_d, mLast_q, mLast_d;
    logic        rxW0, rxW1, mStart;
    logic [31:0] rxV0;
    assign mStart = ctrl_q[CtrlMasterEnBit] && half && !rxFull
                  && (!ctrl_q[CtrlMTrigBit] || globalTrigger);

    always_comb
    begin
        mSt_d = mSt_q; mBit_d = mBit_q; mSh_d = mSh_q; mTmr_d = mTmr_q;
        mSmp_d = mSmp_q; mSmpGo_d = mSmpGo_q; mClk_d = masterClockOut;
        mBad_d = mBad_q; mLast_d = mLast_q; setSErr = 1'b0;
        rxW0 = 1'b0; rxW1 = 1'b0; rxV0 = mSh_q;
        // bit sample after data delay, shifted msb first
        if (mSmpGo_q)
        begin
            if (mSmp_q == 8'h00)
            begin
                mSmpGo_d = 1'b0;
                mSh_d = {mSh_q[30:0], mFlt_q.dat};
            end
            else mSmp_d = mSmp_q - 8'h01;
        end
        case (mSt_q)
            MIdle:
            begin
                mClk_d = 1'b1;
                if (mStart)
                begin
                    if (!mFlt_q.dat) setSErr = 1'b1;
                    mSt_d = MLow; mClk_d = 1'b0; mBit_d = 6'h00; mBad_d = 1'b0;
                    mSh_d = 32'h0;
                end
            end
            MLow:
                if (half)
                begin
                    mClk_d = 1'b1; mSt_d = MHigh;
                    mSmpGo_d = 1'b1; mSmp_d = mDel_q[7:0];
                    if ({1'b0, mBit_q} == {1'b0, lenM1}) mTmr_d = mPause_q;
                end
            MHigh:
                if (half)
                begin
                    if (mBit_q[4:0] == lenM1)
                    begin
                        mSt_d = MPause; mTmr_d = mPause_q;
                        mLast_d = 1'b1;
                    end
                    else
                    begin
                        mClk_d = 1'b0; mSt_d = MLow; mBit_d = mBit_q + 6'h01;
                    end
                end
            MPause:
            begin
                mClk_d = 1'b1;
                // data must stay low from pause start+2*delay until timeout ends
                if (mPause_q - mTmr_q > ({24'h0, mDel_q[7:0]} << TwoDelayShift)
                    && mPause_q - mTmr_q < mTo_q && mFlt_q.dat)
                    mBad_d = 1'b1;
                if (mTmr_q == 32'h0)
                begin
                    mSt_d = MIdle;
                    if (!mFlt_q.dat) mBad_d = 1'b1;
                    if (mBad_d) setSErr = 1'b1;
                    else
                    begin
                        rxW0 = 1'b1;
                        rxW1 = ctrl_q[CtrlStampBit];
                    end
                end
                else mTmr_d = mTmr_q - 32'h1;
            end
            default: mSt_d = MIdle;
        endcase
    end

    // ------------------------------------------------------------
    // slave port: follows incoming clock, shifts out a word
    // ------------------------------------------------------------
    typedef enum {SIdle, SShift, SHold, SPause} slv_e;
    slv_e sSt_q, sSt_d;
    logic [31:0] sSh_q, sSh_d, sTmr_q, sTmr_d;
    logic [7:0]  sDly_q, sDly_d;
    logic [5:0]  sBit_q, sBit_d;
    logic        sPend_q, sPend_d, sPv_q, sPv_d, sOut_d, sClkP_q, sRise, sFall;
    logic [31:0] txHead;
    logic        txPop;
    assign sRise  = sFlt_q.clk && !sClkP_q;
    assign sFall  = !sFlt_q.clk && sClkP_q;
    assign txHead = txMem[txRp_q[TxAw-1:0]];

    always_comb
    begin
        sSt_d = sSt_q; sSh_d = sSh_q; sTmr_d = sTmr_q; sDly_d = sDly_q;
        sBit_d = sBit_q; sPend_d = sPend_q; sPv_d = sPv_q; sOut_d = slaveSerialOut;
        setMErr = 1'b0; txPop = 1'b0;
        // delayed bit update after each rising edge
        if (sPend_q)
        begin
            if (sDly_q == 8'h00)
            begin
                sPend_d = 1'b0; sOut_d = sPv_q;
            end
            else sDly_d = sDly_q - 8'h01;
        end
        case (sSt_q)
            SIdle:
                if (sFall && ctrl_q[CtrlSlaveEnBit] && !txEmpty
                    && (!ctrl_q[CtrlSTrigBit] || globalTrigger))
                begin
                    sSt_d = SShift; txPop = 1'b1;
                    sSh_d = txHead << (6'd31 - {1'b0, lenM1});
                    sBit_d = 6'h00;
                end
            SShift:
            begin
                if (sRise)
                begin
                    sPv_d = sSh_q[31]; sSh_d = {sSh_q[30:0], 1'b0};
                    sPend_d = 1'b1; sDly_d = sDel_q[7:0];
                end
                if (sFall && sBit_q[4:0] == lenM1)
                begin
                    sSt_d = SHold; sTmr_d = sTo_q;
                    sPend_d = 1'b0; sOut_d = 1'b0;
                end
                else if (sFall) sBit_d = sBit_q + 6'h01;
            end
            SHold:
            begin
                sOut_d = 1'b0;
                if (sTmr_q == 32'h0)
                begin
                    sOut_d = 1'b1; sSt_d = SPause; sTmr_d = sPause_q;
                end
                else sTmr_d = sTmr_q - 32'h1;
            end
            SPause:
            begin
                sOut_d = 1'b1;
                if (sFall) setMErr = 1'b1;
                if (sTmr_q == 32'h0) sSt_d = SIdle;
                else sTmr_d = sTmr_q - 32'h1;
            end
            default: sSt_d = SIdle;
        endcase
    end

    // ------------------------------------------------------------
    // fifo pointers and memories
    // ------------------------------------------------------------
    assign rxPop  = rd && paddr == RxDataOfs && !rxEmpty;
    assign txPush = wr && paddr == TxDataOfs && !pslverr;   // refused in setup when full
    always_comb
    begin
        rxWp_d = rxWp_q + {{RxAw{1'b0}}, rxW0} + {{RxAw{1'b0}}, rxW1};
        rxRp_d = rxRp_q + {{RxAw{1'b0}}, rxPop};
        txWp_d = txWp_q + {{TxAw{1'b0}}, txPush};
        txRp_d = txRp_q + {{TxAw{1'b0}}, txPop};
    end
    always_ff @(posedge clk)
    begin
        if (rxW0) rxMem[rxWp_q[RxAw-1:0]] <= rxV0;
        if (rxW1) rxMem[rxWp_q[RxAw-1:0] + 11'h001] <= stamp_q;
        if (txPush) txMem[txWp_q[TxAw-1:0]] <= pwdata;
    end

    // ------------------------------------------------------------
    // register file, status and APB answer
    // ------------------------------------------------------------
    logic [31:0] status;
    always_comb
    begin
        status = 32'h0;
        status[StMErr]   = mErr_q;
        status[StSErr]   = sErr_q;
        status[StTxE]    = txEmpty;
        status[StRxE]    = rxEmpty;
        status[StSBusy]  = (sSt_q != SIdle);
        status[StMBusy]  = (mSt_q != MIdle);
        status[StTxHalf] = (txCnt < TxDepth / 2);
        status[StRxHalf] = (rxCnt > RxDepth / 2);
        status[StTxFull] = txFull;
        status[StRxFull] = rxFull;
    end

    always_comb
    begin
        ctrl_d = ctrl_q; baud_d = baud_q; mDel_d = mDel_q; mPause_d = mPause_q;
        mTo_d = mTo_q; sDel_d = sDel_q; sPause_d = sPause_q; sTo_d = sTo_q;
        deb_d = deb_q; mErr_d = mErr_q; sErr_d = sErr_q;
        pready_d = psel && !penable; pslverr_d = 1'b0; prdata_d = 32'h0;
        if (wr)
            case (paddr)
                CtrlOfs:     ctrl_d = pwdata;
                BaudDivOfs:  baud_d = pwdata;
                MDelayOfs:   mDel_d = {24'h0, pwdata[7:0]};
                MPauseOfs:   mPause_d = pwdata;
                MTimeoutOfs: mTo_d = {16'h0, pwdata[15:0]};
                SDelayOfs:   sDel_d = {24'h0, pwdata[7:0]};
                SPauseOfs:   sPause_d = pwdata;
                STimeoutOfs: sTo_d = {16'h0, pwdata[15:0]};
                DebounceOfs: deb_d = {16'h0, pwdata[15:0]};
                StatusOfs:
                begin
                    if (pwdata[StMErr]) mErr_d = 1'b0;
                    if (pwdata[StSErr]) sErr_d = 1'b0;
                end
                default:     ;
            endcase
        // set wins over a software clear in the same cycle
        if (setMErr) mErr_d = 1'b1;
        if (setSErr) sErr_d = 1'b1;
        if (psel && !penable && !pwrite)
            case (paddr)
                CtrlOfs:     prdata_d = ctrl_q;
                BaudDivOfs:  prdata_d = baud_q;
                MDelayOfs:   prdata_d = mDel_q;
                MPauseOfs:   prdata_d = mPause_q;
                MTimeoutOfs: prdata_d = mTo_q;
                SDelayOfs:   prdata_d = sDel_q;
                SPauseOfs:   prdata_d = sPause_q;
                STimeoutOfs: prdata_d = sTo_q;
                StatusOfs:   prdata_d = status;
                RxDataOfs:   prdata_d = rxMem[rxRp_q[RxAw-1:0]];
                DebounceOfs: prdata_d = deb_q;
                TxDataOfs:   prdata_d = 32'h0;
                default:     pslverr_d = 1'b1;
            endcase
        // write errors decoded in setup so they stand beside pready
        else if (psel && !penable)
            case (paddr)
                CtrlOfs, BaudDivOfs, MDelayOfs, MPauseOfs, MTimeoutOfs, SDelayOfs,
                SPauseOfs, STimeoutOfs, StatusOfs, DebounceOfs: pslverr_d = 1'b0;
                TxDataOfs:   pslverr_d = txFull;
                default:     pslverr_d = 1'b1;
            endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= CtrlReset; baud_q <= BaudDivReset; mDel_q <= DelayReset;
            mPause_q <= PauseReset; mTo_q <= TimeoutReset; sDel_q <= DelayReset;
            sPause_q <= PauseReset; sTo_q <= TimeoutReset; deb_q <= DebounceReset;
            mErr_q <= 1'b0; sErr_q <= 1'b0; prdata <= 32'h0; pready <= 1'b0;
            pslverr <= 1'b0; rxWp_q <= '0; rxRp_q <= '0; txWp_q <= '0; txRp_q <= '0;
            mSt_q <= MIdle; mBit_q <= 6'h00; mSh_q <= 32'h0; mTmr_q <= 32'h0;
            mSmp_q <= 8'h00; mSmpGo_q <= 1'b0; masterClockOut <= 1'b1;
            mBad_q <= 1'b0; mLast_q <= 1'b0; stamp_q <= 32'h0;
            sSt_q <= SIdle; sSh_q <= 32'h0; sTmr_q <= 32'h0; sDly_q <= 8'h00;
            sBit_q <= 6'h00; sPend_q <= 1'b0; sPv_q <= 1'b1; slaveSerialOut <= 1'b1;
            sClkP_q <= 1'b1; fifoFullEvent <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d; baud_q <= baud_d; mDel_q <= mDel_d;
            mPause_q <= mPause_d; mTo_q <= mTo_d; sDel_q <= sDel_d;
            sPause_q <= sPause_d; sTo_q <= sTo_d; deb_q <= deb_d;
            mErr_q <= mErr_d; sErr_q <= sErr_d; prdata <= prdata_d; pready <= pready_d;
            pslverr <= pslverr_d; rxWp_q <= rxWp_d; rxRp_q <= rxRp_d;
            txWp_q <= txWp_d; txRp_q <= txRp_d;
            mSt_q <= mSt_d; mBit_q <= mBit_d; mSh_q <= mSh_d; mTmr_q <= mTmr_d;
            mSmp_q <= mSmp_d; mSmpGo_q <= mSmpGo_d; masterClockOut <= mClk_d;
            mBad_q <= mBad_d; mLast_q <= mLast_d; stamp_q <= stamp_q + 32'h1;
            sSt_q <= sSt_d; sSh_q <= sSh_d; sTmr_q <= sTmr_d; sDly_q <= sDly_d;
            sBit_q <= sBit_d; sPend_q <= sPend_d; sPv_q <= sPv_d;
            slaveSerialOut <= sOut_d; sClkP_q <= sFlt_q.clk;
            // pulse on the cycle a fifo first reaches full
            fifoFullEvent <= (rxFull_nx(rxWp_d, rxRp_d) && !rxFull)
                          || (txWp_d - txRp_d == TxDepth[TxAw:0] && !txFull);
        end
    end

    function automatic logic rxFull_nx(input logic [RxAw:0] w, input logic [RxAw:0] r);
        logic [RxAw:0] d;
        d = w - r;
        return d[RxAw];
    endfunction

endmodule

//--- test/ssi_chan_properties.sv
/* port checker: bus handshake, clock halves, idle levels.
   assumes the reset divider, 34 core cycles a half bit. */
module ssi_chan_properties
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic masterClockOut,
    input wire logic slaveSerialOut,
    input wire logic fifoFullEvent
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // steps of a transfer and of a clock half
    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence lowRun;
        !masterClockOut [*8];
    endsequence

    ready_after_setup_a: assert property (setupPhase |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready too long");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    full_event_pulse_a: assert property (fifoFullEvent |=> !fifoFullEvent)
        else $error("full event too long");
    clock_low_half_a: assert property ($fell(masterClockOut) |-> lowRun)
        else $error("low half too short");
    clock_high_half_a: assert property ($rose(masterClockOut) |-> masterClockOut [*8])
        else $error("high half too short");
    idle_levels_a: assert property (disable iff (1'b0)
        rst ##1 rst |-> masterClockOut && slaveSerialOut)
        else $error("lines not idle high");
endmodule

//--- test/ssi_far_slave.sv
/* far slave model: shifts a fixed word on the master clock rises.
   assumes clk is the channel core clock. */
module ssi_far_slave
#(
    parameter logic [7:0] Word = 8'hb6,
    parameter int         Hold = 6,
    parameter int         Tm   = 128
)
(
    input  wire logic clk,
    input  wire logic sclk,
    output logic      sdat
);
    timeunit 1ns;
    timeprecision 1ps;

    // low hold outlasts the timeout window and ends inside the pause, so no error is due
    initial
    begin
        sdat = 1'b1;
        forever
        begin
            @(negedge sclk);
            for (int n = 7; n >= 0; n--)
            begin
                @(posedge sclk);
                sdat <= Word[n];
            end
            repeat (Hold) @(posedge clk);
            sdat <= 1'b0;
            repeat (Tm) @(posedge clk);
            sdat <= 1'b1;
        end
    end
endmodule

//--- test/tb_top.sv
/* bench: reset values, unmapped read, received and sent words.
   assumes the package reset values and a 4 ns core clock. */
module tb_top
    import ssi_chan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        slaveClockIn = 1'b1, pready, pslverr, masterClockOut, slaveSerialOut;
    logic        masterSerialIn, fifoFullEvent, err, trig = 1'b0, fullSeen = 1'b0;
    logic [7:0]  paddr = 8'h00, txWord = 8'h9c;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    int          fails = 0, total_checks = 0;
    logic [7:0]  rowAddr [7] = '{CtrlOfs, BaudDivOfs, MDelayOfs, MPauseOfs, STimeoutOfs,
                                 DebounceOfs, StatusOfs};
    logic [31:0] rowVal  [7] = '{CtrlReset, BaudDivReset, DelayReset, PauseReset,
                                 TimeoutReset, DebounceReset, 32'h0000_004c};

    always #2 clk = ~clk;

    // latched at the pulse itself, so a check at the next edge already sees it
    always @(posedge fifoFullEvent) fullSeen = 1'b1;

    ssi_chan i_ssi_chan (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .globalTrigger(trig), .pllTick(1'b0), .masterSerialIn,
        .masterClockOut, .slaveClockIn, .slaveSerialOut, .fifoFullEvent);
    ssi_far_slave i_ssi_far_slave (.clk, .sclk(masterClockOut), .sdat(masterSerialIn));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            fails++;
            $display("[ERR] %0t saw %h want %h", $time, seen, want);
        end
    endtask

    // idle cycle at the end keeps back-to-back calls from clashing
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic link(input logic v, input int n);
        slaveClockIn <= v;
        repeat (n) @(posedge clk);
    endtask

    task automatic stop_test();
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rowAddr[i])
        begin
            apb(1'b0, rowAddr[i], 32'h0);
            check(q, rowVal[i]);
        end
        apb(1'b0, 8'h30, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 8'h30, 32'h0);
        check(err, 1'b1);
        // far slave word, sampled four cycles after each rise
        apb(1'b1, MDelayOfs, 32'h4);
        check(err, 1'b0);
        apb(1'b1, MTimeoutOfs, 32'h40);
        apb(1'b1, CtrlOfs, 32'h0701);
        repeat (1000) @(posedge clk);
        apb(1'b1, CtrlOfs, 32'h0700);
        repeat (1000) @(posedge clk);
        apb(1'b0, StatusOfs, 32'h0);
        check(q[StSErr], 1'b0);
        check(q[StRxE], 1'b0);
        apb(1'b0, RxDataOfs, 32'h0);
        check(q, 32'h0000_00b6);
        // sent word, then a clock that comes back inside the pause
        apb(1'b1, SPauseOfs, 32'h400);
        apb(1'b1, TxDataOfs, {24'h0, txWord});
        apb(1'b1, CtrlOfs, 32'h070a);
        check(slaveSerialOut, 1'b1);
        // gated start: a falling clock without the trigger leaves the port idle
        link(1'b0, 16);
        link(1'b1, 15);
        apb(1'b0, StatusOfs, 32'h0);
        check(q[StSBusy], 1'b0);
        trig <= 1'b1;
        for (int k = 7; k >= 0; k--)
        begin
            link(1'b0, 16);
            link(1'b1, 15);
            check(slaveSerialOut, txWord[k]);
        end
        link(1'b0, 12);
        check(slaveSerialOut, 1'b0);
        link(1'b1, 270);
        check(slaveSerialOut, 1'b1);
        link(1'b0, 16);
        link(1'b1, 15);
        apb(1'b0, StatusOfs, 32'h0);
        check(q[StMErr], 1'b1);
        apb(1'b1, StatusOfs, 32'h1);
        apb(1'b0, StatusOfs, 32'h0);
        check(q[StMErr], 1'b0);
        // fill the transmit fifo; one write past full is refused
        repeat (TxDepth - 1) apb(1'b1, TxDataOfs, 32'h0);
        check(fullSeen, 1'b0);
        apb(1'b1, TxDataOfs, 32'h0);
        check(fullSeen, 1'b1);
        apb(1'b0, StatusOfs, 32'h0);
        check(q[StTxFull], 1'b1);
        apb(1'b1, TxDataOfs, 32'h0);
        check(err, 1'b1);
        stop_test();
    end
endmodule

bind ssi_chan ssi_chan_properties i_ssi_chan_properties (.clk, .rst, .psel, .penable,
    .pready, .pslverr, .masterClockOut, .slaveSerialOut, .fifoFullEvent);
